// >>> plc_pkg.sv
// Constants for the synthesizer loop-filter and calibration control bank.
// Assumes an 8-bit register port and a 10 MHz always-on clock.
package plc_pkg;
	// Register port widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [7:0] OFF_PLL1_LOOP_FILTER = 8'h76;
	localparam logic [7:0] OFF_PLL1_CAL_WAIT = 8'h77;
	localparam logic [7:0] OFF_PLL1_CAL_DELAY = 8'h78;
	localparam logic [7:0] OFF_PLL2_PUMP_WIDTH = 8'h83;
	localparam logic [7:0] OFF_PLL2_LOOP_FILTER = 8'h84;
	localparam logic [7:0] OFF_SEQ_CTRL = 8'hF0;
	localparam logic [7:0] OFF_SEQ_STAT = 8'hF1;

	// Field positions and widths
	localparam int FILT_LSB = 0;
	localparam int FILT_W = 3;
	localparam int WAIT_W = 2;
	localparam int VCO_WAIT_LSB = 0;
	localparam int CLSD_WAIT_LSB = 2;
	localparam int CAL_DELAY_BIT = 0;
	localparam int STRETCH_BIT = 7;
	localparam int START_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_PHASE_LSB = 2;
	localparam int PHASE_W = 2;

	// Reset values and filter codes
	localparam logic [2:0] FILT_2ND_ORDER = 3'h3;
	localparam logic [2:0] FILT_3RD_ORDER = 3'h7;
	localparam logic [2:0] FILT_RST = FILT_2ND_ORDER;
	localparam logic [1:0] CLSD_WAIT_RST = 2'h0;
	localparam logic [1:0] VCO_WAIT_RST = 2'h1;
	localparam logic CAL_DELAY_RST = 1'b0;
	localparam logic STRETCH_RST = 1'b0;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// Clock rate and wait times in their own units
	localparam int CLK_KHZ = 10000;
	localparam int CLSD_T0_US = 30;
	localparam int CLSD_T1_US = 300;
	localparam int CLSD_T2_MS = 30;
	localparam int CLSD_T3_MS = 300;
	localparam int VCO_T0_US = 20;
	localparam int VCO_T1_US = 400;
	localparam int VCO_T2_MS = 8;
	localparam int VCO_T3_MS = 200;
	localparam int CAL_DELAY_MS = 60;

	// Wait times as clock cycles
	localparam int CLSD_CYC0 = CLSD_T0_US * CLK_KHZ / 1000;
	localparam int CLSD_CYC1 = CLSD_T1_US * CLK_KHZ / 1000;
	localparam int CLSD_CYC2 = CLSD_T2_MS * CLK_KHZ;
	localparam int CLSD_CYC3 = CLSD_T3_MS * CLK_KHZ;
	localparam int VCO_CYC0 = VCO_T0_US * CLK_KHZ / 1000;
	localparam int VCO_CYC1 = VCO_T1_US * CLK_KHZ / 1000;
	localparam int VCO_CYC2 = VCO_T2_MS * CLK_KHZ;
	localparam int VCO_CYC3 = VCO_T3_MS * CLK_KHZ;
	localparam int CAL_DELAY_CYC = CAL_DELAY_MS * CLK_KHZ;
	localparam int CNT_W = 22;

	// Sequencer phase codes shown in the status register
	localparam logic [1:0] PHASE_IDLE = 2'h0;
	localparam logic [1:0] PHASE_DELAY = 2'h1;
	localparam logic [1:0] PHASE_VCO = 2'h2;
	localparam logic [1:0] PHASE_CLSD = 2'h3;

	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_DELAY,
		SEQ_VCO,
		SEQ_CLSD
	} plc_seq_state_t;
endpackage

// >>> plc_cal_seq.sv
// Calibration wait sequencer of the first synthesizer.
// Assumes codes are stable while busy and start is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module plc_cal_seq #(
	parameter int CNT_W = plc_pkg::CNT_W,
	parameter int CLSD_CYC2 = plc_pkg::CLSD_CYC2,
	parameter int CLSD_CYC3 = plc_pkg::CLSD_CYC3,
	parameter int VCO_CYC2 = plc_pkg::VCO_CYC2,
	parameter int VCO_CYC3 = plc_pkg::VCO_CYC3,
	parameter int CAL_DELAY_CYC = plc_pkg::CAL_DELAY_CYC
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic cal_delay_en,
	input wire logic [1:0] vco_settle_wait,
	input wire logic [1:0] closed_loop_wait,
	output logic busy,
	output logic done,
	output logic vco_cal_run,
	output logic [1:0] phase
);
	plc_pkg::plc_seq_state_t state;
	plc_pkg::plc_seq_state_t next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;

	// Counter load value for a wait of c cycles, one less since zero ends it
	function automatic logic [CNT_W-1:0] load_of(input int c);
		load_of = CNT_W'(c - 1);
	endfunction

	// Code to cycle count; both wait fields share this table shape
	function automatic logic [CNT_W-1:0] pick(input logic [1:0] code,
		input int c0, input int c1, input int c2, input int c3);
		case (code)
			2'h0: pick = load_of(c0);
			2'h1: pick = load_of(c1);
			2'h2: pick = load_of(c2);
			default: pick = load_of(c3);
		endcase
	endfunction

	// Delay, then VCO wait, then closed-loop wait
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			plc_pkg::SEQ_IDLE: begin
				if (start && cal_delay_en) begin
					next_state = plc_pkg::SEQ_DELAY;
					next_cnt = load_of(CAL_DELAY_CYC);
				end else if (start) begin
					next_state = plc_pkg::SEQ_VCO;
					next_cnt = pick(vco_settle_wait, plc_pkg::VCO_CYC0, plc_pkg::VCO_CYC1,
						VCO_CYC2, VCO_CYC3);
				end
			end
			plc_pkg::SEQ_DELAY: begin
				if (cnt == '0) begin
					next_state = plc_pkg::SEQ_VCO;
					next_cnt = pick(vco_settle_wait, plc_pkg::VCO_CYC0, plc_pkg::VCO_CYC1,
						VCO_CYC2, VCO_CYC3);
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			plc_pkg::SEQ_VCO: begin
				if (cnt == '0) begin
					next_state = plc_pkg::SEQ_CLSD;
					next_cnt = pick(closed_loop_wait, plc_pkg::CLSD_CYC0, plc_pkg::CLSD_CYC1,
						CLSD_CYC2, CLSD_CYC3);
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			plc_pkg::SEQ_CLSD: begin
				if (cnt == '0) begin
					next_state = plc_pkg::SEQ_IDLE;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			default: begin
				next_state = plc_pkg::SEQ_IDLE;
				next_cnt = '0;
			end
		endcase
	end

	// State and counter
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state <= plc_pkg::SEQ_IDLE;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// Registered views of the next state so every output is a flop
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			busy <= 1'b0;
			vco_cal_run <= 1'b0;
			phase <= plc_pkg::PHASE_IDLE;
		end else begin
			busy <= (next_state != plc_pkg::SEQ_IDLE);
			vco_cal_run <= (next_state == plc_pkg::SEQ_VCO) || (next_state == plc_pkg::SEQ_CLSD);
			case (next_state)
				plc_pkg::SEQ_DELAY: phase <= plc_pkg::PHASE_DELAY;
				plc_pkg::SEQ_VCO: phase <= plc_pkg::PHASE_VCO;
				plc_pkg::SEQ_CLSD: phase <= plc_pkg::PHASE_CLSD;
				default: phase <= plc_pkg::PHASE_IDLE;
			endcase
		end
	end

	// Done stays until the next accepted start
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			done <= 1'b0;
		end else if (state == plc_pkg::SEQ_CLSD && next_state == plc_pkg::SEQ_IDLE) begin
			done <= 1'b1;
		end else if (state == plc_pkg::SEQ_IDLE && start) begin
			done <= 1'b0;
		end
	end
endmodule // plc_cal_seq
`default_nettype wire

// >>> plc_pll_loop_cal_ctrl.sv
// Loop-filter, pump-width and calibration wait registers for two synthesizers.
// Assumes a single-cycle strobe register port on core_clk with no wait states.
// Register map, offsets in hex; bits not listed read zero and ignore writes
// 76 [2:0] first synthesizer filter order, reset 3
// 77 [3:2] closed-loop wait code, reset 0
// 77 [1:0] VCO settle wait code, reset 1
// 78 [0] calibration delay enable, reset 0
// 83 [7] second synthesizer pump-width stretch, reset 0
// 84 [2:0] second synthesizer filter order, reset 3
// F0 [0] write 1 to start the calibration waits; reads zero
// F1 [0] sequencer busy
// F1 [1] sequence done, held until the next accepted start
// F1 [3:2] sequencer phase: 0 idle, 1 delay, 2 VCO wait, 3 closed-loop wait
// F1 ignores writes; any other offset ignores writes and reads zero
//
// Bus use
// A write is one cycle of wr_en beside addr and wdata; the port never waits.
// A read is one cycle of rd_en; rdata carries the answer in the next cycle only.
// Read data fall back to zero after that cycle.
// The strobes never rise together; back-to-back transfers are allowed.
// Addresses are decoded in full, so no register has an alias.
//
// Timing and limitations
// Field outputs change on the edge that takes the write.
// A start is acted on two edges after its write, and ignored while busy.
// Wait codes are sampled as each phase loads, so a write during a run
// only changes phases that have not begun yet.
// The 60 ms delay is counted exactly; the allowed spread is left unused.
// Reserved filter codes are kept as written, since the loop filter
// decoder lives elsewhere; software must not write them.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module plc_pll_loop_cal_ctrl #(
	parameter int CLSD_CYC2 = plc_pkg::CLSD_CYC2,
	parameter int CLSD_CYC3 = plc_pkg::CLSD_CYC3,
	parameter int VCO_CYC2 = plc_pkg::VCO_CYC2,
	parameter int VCO_CYC3 = plc_pkg::VCO_CYC3,
	parameter int CAL_DELAY_CYC = plc_pkg::CAL_DELAY_CYC
) (
	// Clock, reset and register port
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [plc_pkg::ADDR_W-1:0] addr,
	input wire logic [plc_pkg::DATA_W-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [plc_pkg::DATA_W-1:0] rdata,
	// Loop-filter and pump-width fields
	output logic [2:0] pll1_filter_order_sel,
	output logic [2:0] pll2_filter_order_sel,
	output logic pll2_pump_width_stretch,
	// Calibration sequencer status
	output logic pll1_cal_busy,
	output logic pll1_cal_done,
	output logic pll1_vco_cal_run
);
	// Fields kept inside the block and sequencer wiring
	logic [1:0] closed_loop_wait;
	logic [1:0] vco_settle_wait;
	logic pll1_cal_delay_en;
	logic seq_start;
	logic [1:0] seq_phase;
	logic [plc_pkg::DATA_W-1:0] next_rdata;

	// Write hit on one offset
	// Exact match; aliases would let a stray write hit a field
	function automatic logic wr_hit(input logic [plc_pkg::ADDR_W-1:0] a,
		input logic [plc_pkg::ADDR_W-1:0] off, input logic we);
		wr_hit = we && (a == off);
	endfunction

	// First synthesizer filter order; reserved codes are stored as written
	// Output drives the loop filter switches directly, with no staging copy
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pll1_filter_order_sel <= plc_pkg::FILT_RST;
		end else if (wr_hit(addr, plc_pkg::OFF_PLL1_LOOP_FILTER, wr_en)) begin
			pll1_filter_order_sel <= wdata[plc_pkg::FILT_LSB +: plc_pkg::FILT_W];
		end
	end

	// Second synthesizer filter order, same encoding as the first
	// Kept apart from the first so each synthesizer can change alone
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pll2_filter_order_sel <= plc_pkg::FILT_RST;
		end else if (wr_hit(addr, plc_pkg::OFF_PLL2_LOOP_FILTER, wr_en)) begin
			pll2_filter_order_sel <= wdata[plc_pkg::FILT_LSB +: plc_pkg::FILT_W];
		end
	end

	// Closed-loop wait code; changing it mid-sequence affects only later loads
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			closed_loop_wait <= plc_pkg::CLSD_WAIT_RST;
		end else if (wr_hit(addr, plc_pkg::OFF_PLL1_CAL_WAIT, wr_en)) begin
			closed_loop_wait <= wdata[plc_pkg::CLSD_WAIT_LSB +: plc_pkg::WAIT_W];
		end
	end

	// VCO settle wait code, sharing the byte with the closed-loop code
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			vco_settle_wait <= plc_pkg::VCO_WAIT_RST;
		end else if (wr_hit(addr, plc_pkg::OFF_PLL1_CAL_WAIT, wr_en)) begin
			vco_settle_wait <= wdata[plc_pkg::VCO_WAIT_LSB +: plc_pkg::WAIT_W];
		end
	end

	// Calibration delay enable
	// Read when a start is taken; a later write affects only the next run
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pll1_cal_delay_en <= plc_pkg::CAL_DELAY_RST;
		end else if (wr_hit(addr, plc_pkg::OFF_PLL1_CAL_DELAY, wr_en)) begin
			pll1_cal_delay_en <= wdata[plc_pkg::CAL_DELAY_BIT];
		end
	end

	// Charge-pump minimum pulse stretch
	// Bit sits at the top of its byte; the lower bits are reserved
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pll2_pump_width_stretch <= plc_pkg::STRETCH_RST;
		end else if (wr_hit(addr, plc_pkg::OFF_PLL2_PUMP_WIDTH, wr_en)) begin
			pll2_pump_width_stretch <= wdata[plc_pkg::STRETCH_BIT];
		end
	end

	// Start pulse; registered so the sequencer sees a clean one-cycle request
	// Bit reads back zero, so a read-modify-write cannot restart a run
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			seq_start <= 1'b0;
		end else begin
			seq_start <= wr_hit(addr, plc_pkg::OFF_SEQ_CTRL, wr_en) && wdata[plc_pkg::START_BIT];
		end
	end

	// Wait sequencer; a start while busy is ignored inside it
	// Long phases are parameters so a bench can shorten them
	plc_cal_seq #(
		.CNT_W(plc_pkg::CNT_W),
		.CLSD_CYC2(CLSD_CYC2),
		.CLSD_CYC3(CLSD_CYC3),
		.VCO_CYC2(VCO_CYC2),
		.VCO_CYC3(VCO_CYC3),
		.CAL_DELAY_CYC(CAL_DELAY_CYC)
	) u_cal_seq (
		.core_clk(core_clk),
		.resetn(resetn),
		.start(seq_start),
		.cal_delay_en(pll1_cal_delay_en),
		.vco_settle_wait(vco_settle_wait),
		.closed_loop_wait(closed_loop_wait),
		.busy(pll1_cal_busy),
		.done(pll1_cal_done),
		.vco_cal_run(pll1_vco_cal_run),
		.phase(seq_phase)
	);

	// Read mux; reserved bits and unmapped offsets read zero
	// Status bits come from sequencer flops loaded from the next state, so they change on the same edge as the state
	always_comb begin
		next_rdata = plc_pkg::READ_ZERO;
		case (addr)
			plc_pkg::OFF_PLL1_LOOP_FILTER: begin
				next_rdata[plc_pkg::FILT_LSB +: plc_pkg::FILT_W] = pll1_filter_order_sel;
			end
			plc_pkg::OFF_PLL1_CAL_WAIT: begin
				next_rdata[plc_pkg::CLSD_WAIT_LSB +: plc_pkg::WAIT_W] = closed_loop_wait;
				next_rdata[plc_pkg::VCO_WAIT_LSB +: plc_pkg::WAIT_W] = vco_settle_wait;
			end
			plc_pkg::OFF_PLL1_CAL_DELAY: begin
				next_rdata[plc_pkg::CAL_DELAY_BIT] = pll1_cal_delay_en;
			end
			plc_pkg::OFF_PLL2_PUMP_WIDTH: begin
				next_rdata[plc_pkg::STRETCH_BIT] = pll2_pump_width_stretch;
			end
			plc_pkg::OFF_PLL2_LOOP_FILTER: begin
				next_rdata[plc_pkg::FILT_LSB +: plc_pkg::FILT_W] = pll2_filter_order_sel;
			end
			plc_pkg::OFF_SEQ_CTRL: begin
				next_rdata = plc_pkg::READ_ZERO; // Start bit is write-only
			end
			plc_pkg::OFF_SEQ_STAT: begin
				next_rdata[plc_pkg::STAT_BUSY_BIT] = pll1_cal_busy;
				next_rdata[plc_pkg::STAT_DONE_BIT] = pll1_cal_done;
				next_rdata[plc_pkg::STAT_PHASE_LSB +: plc_pkg::PHASE_W] = seq_phase;
			end
			default: begin
				next_rdata = plc_pkg::READ_ZERO;
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe
	// Zero between reads keeps the bus quiet for a shared read path
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= plc_pkg::READ_ZERO;
		end else if (rd_en) begin
			rdata <= next_rdata;
		end else begin
			rdata <= plc_pkg::READ_ZERO;
		end
	end
endmodule // plc_pll_loop_cal_ctrl
`default_nettype wire

// >>> plc_ctrl_properties.sv
// Checker for the loop-filter and calibration control bank.
// Sees only the top module's ports; bound to every instance below.
`timescale 1ns/1ps
`default_nettype none
module plc_ctrl_properties (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] rdata,
	input wire logic [2:0] pll1_filter_order_sel,
	input wire logic [2:0] pll2_filter_order_sel,
	input wire logic pll2_pump_width_stretch,
	input wire logic pll1_cal_busy,
	input wire logic pll1_cal_done,
	input wire logic pll1_vco_cal_run
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// Field outputs follow writes one edge later; reads reflect the fields
	f1_write_a: assert property (wr_en && addr == 8'h76 |=>
		pll1_filter_order_sel == $past(wdata[2:0])) else $error("pll1 filter write lost");
	f2_write_a: assert property (wr_en && addr == 8'h84 |=>
		pll2_filter_order_sel == $past(wdata[2:0])) else $error("pll2 filter write lost");
	stretch_write_a: assert property (wr_en && addr == 8'h83 |=>
		pll2_pump_width_stretch == $past(wdata[7])) else $error("stretch write lost");
	f1_read_a: assert property (rd_en && addr == 8'h76 |=>
		rdata == {5'h00, pll1_filter_order_sel}) else $error("pll1 filter readback wrong");
	stretch_read_a: assert property (rd_en && addr == 8'h83 |=>
		rdata == {pll2_pump_width_stretch, 7'h00}) else $error("stretch readback wrong");
	// Sequencer: run only inside busy, start seen two edges on, done at the end
	run_in_busy_a: assert property (pll1_vco_cal_run |-> pll1_cal_busy)
		else $error("vco run outside busy");
	start_busy_a: assert property (wr_en && addr == 8'hF0 && wdata[0] && !pll1_cal_busy
		|-> ##2 (pll1_cal_busy && !pll1_cal_done)) else $error("start not taken");
	done_end_a: assert property ($fell(pll1_cal_busy) |->
		pll1_cal_done && !pll1_vco_cal_run) else $error("sequence end wrong");
	cover property ($fell(pll1_cal_busy));
	cover property ($rose(pll1_vco_cal_run));
	cover property (wr_en && addr == 8'h84 && wdata[2:0] == 3'h7);
endmodule // plc_ctrl_properties

bind plc_pll_loop_cal_ctrl plc_ctrl_properties u_props (
	.core_clk(core_clk),
	.resetn(resetn),
	.addr(addr),
	.wdata(wdata),
	.wr_en(wr_en),
	.rd_en(rd_en),
	.rdata(rdata),
	.pll1_filter_order_sel(pll1_filter_order_sel),
	.pll2_filter_order_sel(pll2_filter_order_sel),
	.pll2_pump_width_stretch(pll2_pump_width_stretch),
	.pll1_cal_busy(pll1_cal_busy),
	.pll1_cal_done(pll1_cal_done),
	.pll1_vco_cal_run(pll1_vco_cal_run)
);
`default_nettype wire

// >>> test_pll_loop_and_cal_control.sv
// Self-checking bench for the loop-filter and calibration control bank.
// Drives the register port directly; long waits are shortened by parameters.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_pll_loop_and_cal_control;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rdata;
	logic [2:0] sel1;
	logic [2:0] sel2;
	logic stretch;
	logic busy;
	logic done;
	logic run;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	// Shortened codes 2 and 3 match the parameters handed to the design
	int vco_n[4] = '{plc_pkg::VCO_CYC0, plc_pkg::VCO_CYC1, 10, 15};
	int clsd_n[4] = '{plc_pkg::CLSD_CYC0, plc_pkg::CLSD_CYC1, 20, 30};

	always #50 core_clk = ~core_clk;

	plc_pll_loop_cal_ctrl #(.CLSD_CYC2(20), .CLSD_CYC3(30), .VCO_CYC2(10), .VCO_CYC3(15),
		.CAL_DELAY_CYC(40)) u_dut (.core_clk(core_clk), .resetn(resetn), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.pll1_filter_order_sel(sel1), .pll2_filter_order_sel(sel2),
		.pll2_pump_width_stretch(stretch), .pll1_cal_busy(busy), .pll1_cal_done(done),
		.pll1_vco_cal_run(run));

	task automatic final_report();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Bus cycles leave one idle cycle so a strobe is never driven twice in a step
	// A write returns just after its edge, once the fields have settled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr_en <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask

	task automatic t_reset();
		`CHK({sel1, sel2, stretch, busy, done, run, rdata}, {3'h3, 3'h3, 4'h0, 8'h00})
		rd(8'h76, 8'h03);
		rd(8'h84, 8'h03);
		rd(8'h77, 8'h01);
		rd(8'h78, 8'h00);
		rd(8'h83, 8'h00);
		wr(8'h50, 8'hFF);
		rd(8'h50, 8'h00);
	endtask

	// Every code, reserved ones too, is stored; upper bits read as zero
	task automatic t_filter();
		for (int i = 0; i < 8; i++) begin
			wr(8'h76, 8'hF8 | 8'(i));
			wr(8'h84, 8'(7 - i));
			`CHK({sel1, sel2}, {3'(i), 3'(7 - i)})
			rd(8'h76, 8'(i));
			rd(8'h84, 8'(7 - i));
		end
	endtask

	task automatic t_stretch();
		wr(8'h83, 8'hFF);
		`CHK(stretch, 1'b1)
		rd(8'h83, 8'h80);
		wr(8'h83, 8'h7F);
		`CHK(stretch, 1'b0)
	endtask

	// Counts busy and run cycles; a second start mid-run must change nothing
	task automatic t_seq(input int v, input int c, input int d, input bit dbl);
		int nb;
		int nr;
		wr(8'h77, 8'(c * 4 + v));
		wr(8'h78, 8'(d));
		rd(8'h77, 8'(c * 4 + v));
		rd(8'h78, 8'(d));
		wr(8'hF0, 8'h01);
		rd(8'hF1, (d != 0) ? 8'h05 : 8'h09);
		// The first busy cycle passed during the status read
		nb = 1;
		nr = int'(d == 0);
		for (int k = 0; k < 9000 && !(nb > 0 && busy !== 1'b1); k++) begin
			@(posedge core_clk);
			nb += int'(busy === 1'b1);
			nr += int'(run === 1'b1);
			addr <= 8'hF0;
			wr_en <= dbl && nb == 9;
		end
		`CHK(nb, d * 40 + vco_n[v] + clsd_n[c])
		`CHK(nr, vco_n[v] + clsd_n[c])
		rd(8'hF1, 8'h02);
	endtask

	// Hang guard: full run needs about 7800 cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end

	initial begin
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_filter();
		t_stretch();
		t_seq(0, 0, 0, 1'b0);
		t_seq(1, 1, 0, 1'b1);
		t_seq(2, 2, 1, 1'b0);
		t_seq(3, 3, 1, 1'b1);
		final_report();
	end
endmodule // test_pll_loop_and_cal_control
`default_nettype wire
